// ---- logic/tcc_pkg.sv ----
// Constants, types and encodings shared by the Type-C pin-function block.
// Assumes a 200 MHz system clock and an I2C link clocked by the bus SCL.
//
// How it works
// - Mid or floating strap selects non-I2C pin outputs
// - Address pin becomes connect-detect after strap latch
// - Connect-detect high when attached, low otherwise
// - I2C mode: open-drain interrupt pulls low on change
// - Non-I2C mode: audio accessory pulls flag low
// - Current codes: medium 10, high 00, default 11
// - I2C mode: pins carry open-drain SDA and SCL
// - Host-role indicator low when DFP sees UFP
// - Enable high runs, enable low hibernates
// - Registers 02H, 09H, 18H survive hibernation
// - Strap latched at power-up picks address or mode
// - Register 09H bit 0 resets to one
// - Interrupt on attach, detach or Rp change

package tcc_pkg;

  // Target addresses in 8-bit write form
  localparam logic [7:0] I2C_ADDR_HI = 8'h7C;
  localparam logic [7:0] I2C_ADDR_LO = 8'h3C;

  // Register offsets
  localparam logic [7:0] REG_CFG  = 8'h02;
  localparam logic [7:0] REG_CTRL = 8'h09;
  localparam logic [7:0] REG_EXT  = 8'h18;
  localparam logic [7:0] REG_EVT  = 8'h19;

  // Reset values
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] EXT_RST  = 8'h00;

  // Field positions
  localparam int CTRL_CONDET_DIS = 0;
  localparam int EVT_ATTACH      = 0;
  localparam int EVT_RP          = 1;

  // Strap latch interval
  localparam int STRAP_LATCH_NS = 10000;
  localparam int CLK_PERIOD_PS  = 5000;
  localparam logic [11:0] STRAP_LATCH_CYC =
    12'((STRAP_LATCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    STRAP_LO  = 2'b00,
    STRAP_MID = 2'b01,
    STRAP_HI  = 2'b10
  } tcc_strap_t;

  typedef enum logic [1:0] {
    MODE_WAIT   = 2'b00,
    MODE_PLAIN  = 2'b01,
    MODE_I2C_HI = 2'b10,
    MODE_I2C_LO = 2'b11
  } tcc_mode_t;

  typedef enum logic [1:0] {
    RP_NONE = 2'b00,
    RP_DEF  = 2'b01,
    RP_MED  = 2'b10,
    RP_HIGH = 2'b11
  } tcc_rp_t;

  typedef enum logic [2:0] {
    LK_ADDR  = 3'b000,
    LK_ACK_A = 3'b001,
    LK_WR    = 3'b010,
    LK_ACK_W = 3'b011,
    LK_RD    = 3'b100,
    LK_ACK_R = 3'b101,
    LK_IDLE  = 3'b110
  } tcc_lk_state_t;

endpackage

// ---- logic/tcc_link_if.sv ----
// Signals between the system-clock core and the SCL-clocked I2C target.
// Assumes run is a flop of the core and acts as the link's frame reset.
`timescale 1ns/1ps

interface tcc_link_if;
  logic       run;
  logic       sda_in;
  logic [7:0] i2c_addr;
  logic [7:0] status_snap;
  logic       sda_oe;
  logic [7:0] ctrl_reg;
  logic       clr_tgl;

  modport core (
    output run,
    output sda_in,
    output i2c_addr,
    output status_snap,
    input  sda_oe,
    input  ctrl_reg,
    input  clr_tgl
  );

  modport link (
    input  run,
    input  sda_in,
    input  i2c_addr,
    input  status_snap,
    output sda_oe,
    output ctrl_reg,
    output clr_tgl
  );
endinterface

// ---- logic/tcc_i2c_link.sv ----
// I2C target clocked by SCL, holding the retained configuration registers.
// Assumes the core holds run low outside frames, releasing it with SCL low.
`timescale 1ns/1ps

module tcc_i2c_link (
  // Link clock and power-on reset
  input wire logic     scl_clk_i,
  input wire logic     arst_n_i,
  // Core side
  tcc_link_if.link     lk
);

  tcc_pkg::tcc_lk_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic       rw_r;
  logic       first_r;
  logic       sda_oe_r;
  logic [7:0] ptr_r;
  logic [7:0] cfg_r;
  logic [7:0] ctrl_r;
  logic [7:0] ext_r;
  logic       clr_tgl_r;

  wire        frm_rst_n = arst_n_i & lk.run;
  wire [7:0]  byte_w    = {shift_r[6:0], lk.sda_in};
  wire        last_w    = (bit_cnt_r == 3'h7);
  wire        shifting  = (state_r == tcc_pkg::LK_ADDR) ||
                          (state_r == tcc_pkg::LK_WR) ||
                          (state_r == tcc_pkg::LK_RD);
  wire        wr_fire   = lk.run & (state_r == tcc_pkg::LK_WR) & last_w;
  wire        rd_fire   = lk.run &
                          (((state_r == tcc_pkg::LK_ACK_A) & rw_r) |
                           ((state_r == tcc_pkg::LK_ACK_R) & ~lk.sda_in));
  wire [7:0]  rd_data   =
    (ptr_r == tcc_pkg::REG_CFG)  ? cfg_r :
    (ptr_r == tcc_pkg::REG_CTRL) ? ctrl_r :
    (ptr_r == tcc_pkg::REG_EXT)  ? ext_r :
    (ptr_r == tcc_pkg::REG_EVT)  ? lk.status_snap : 8'h00;

  // Frame sequencer, sampled on SCL rising
  always_ff @(posedge scl_clk_i or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      state_r   <= tcc_pkg::LK_ADDR;
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      rw_r      <= 1'b0;
      first_r   <= 1'b1;
    end else begin
      shift_r   <= byte_w;
      bit_cnt_r <= shifting ? bit_cnt_r + 3'h1 : 3'h0;
      if (rd_fire) begin
        tx_r <= rd_data;
      end
      case (state_r)
        tcc_pkg::LK_ADDR: begin
          if (last_w) begin
            rw_r    <= byte_w[0];
            state_r <= (byte_w[7:1] == lk.i2c_addr[7:1]) ?
                       tcc_pkg::LK_ACK_A : tcc_pkg::LK_IDLE;
          end
        end
        tcc_pkg::LK_ACK_A: begin
          first_r <= 1'b1;
          state_r <= rw_r ? tcc_pkg::LK_RD : tcc_pkg::LK_WR;
        end
        tcc_pkg::LK_WR: begin
          if (last_w) begin
            first_r <= 1'b0;
            state_r <= tcc_pkg::LK_ACK_W;
          end
        end
        tcc_pkg::LK_ACK_W: state_r <= tcc_pkg::LK_WR;
        tcc_pkg::LK_RD: begin
          if (last_w) begin
            state_r <= tcc_pkg::LK_ACK_R;
          end
        end
        tcc_pkg::LK_ACK_R: begin
          state_r <= lk.sda_in ? tcc_pkg::LK_IDLE : tcc_pkg::LK_RD;
        end
        default: state_r <= tcc_pkg::LK_IDLE;
      endcase
    end
  end

  // Registers keep their value across frames and hibernation
  always_ff @(posedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_r     <= 8'h00;
      cfg_r     <= tcc_pkg::CFG_RST;
      ctrl_r    <= tcc_pkg::CTRL_RST;
      ext_r     <= tcc_pkg::EXT_RST;
      clr_tgl_r <= 1'b0;
    end else begin
      if (wr_fire && first_r) begin
        ptr_r <= byte_w;
      end else if (wr_fire) begin
        ptr_r <= ptr_r + 8'h01;
        if (ptr_r == tcc_pkg::REG_CFG) begin
          cfg_r <= byte_w;
        end
        if (ptr_r == tcc_pkg::REG_CTRL) begin
          ctrl_r <= byte_w;
        end
        if (ptr_r == tcc_pkg::REG_EXT) begin
          ext_r <= byte_w;
        end
      end else if (rd_fire) begin
        ptr_r <= ptr_r + 8'h01;
        if (ptr_r == tcc_pkg::REG_EVT) begin
          clr_tgl_r <= ~clr_tgl_r;
        end
      end
    end
  end

  // Data and acknowledge change while SCL is low
  always_ff @(negedge scl_clk_i or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      sda_oe_r <= 1'b0;
    end else if (state_r == tcc_pkg::LK_ACK_A ||
                 state_r == tcc_pkg::LK_ACK_W) begin
      sda_oe_r <= 1'b1;
    end else if (state_r == tcc_pkg::LK_RD) begin
      sda_oe_r <= ~tx_r[3'h7 - bit_cnt_r];
    end else begin
      sda_oe_r <= 1'b0;
    end
  end

  assign lk.sda_oe   = sda_oe_r;
  assign lk.ctrl_reg = ctrl_r;
  assign lk.clr_tgl  = clr_tgl_r;

endmodule

// ---- logic/tcc_pin_mux.sv ----
// Pin-function and status-output logic of the Type-C channel detector.
// Assumes pads resolve open-drain and push-pull levels from the enables;
// detector status inputs and straps are asynchronous to clock_i.
`timescale 1ns/1ps

module tcc_pin_mux (
  // Clocks and reset
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic       scl_clk_i,
  // Straps and enable
  input  wire logic [1:0] strap_level_i,
  input  wire logic       enable_i,
  // Detector status
  input  wire logic       cc_attached_i,
  input  wire logic       audio_acc_i,
  input  wire logic [1:0] rp_code_i,
  input  wire logic       dfp_role_i,
  input  wire logic       ufp_valid_i,
  // Address strap pad, later connect detect
  output logic            connect_detect_out_o,
  output logic            connect_detect_out_oe_o,
  // Interrupt or audio flag pad, open drain
  output logic            irq_audio_pin_o,
  output logic            irq_audio_pin_oe_o,
  // Data or low current-code pad
  input  wire logic       sda_pin_i,
  output logic            sda_pin_o,
  output logic            sda_pin_oe_o,
  // Clock or high current-code pad
  input  wire logic       scl_pin_i,
  output logic            scl_pin_o,
  output logic            scl_pin_oe_o,
  // Host role indicator, open drain
  output logic            host_role_indicator_o,
  output logic            host_role_indicator_oe_o
);

  tcc_link_if lk ();

  tcc_i2c_link u_link (
    .scl_clk_i (scl_clk_i),
    .arst_n_i  (arst_n_i),
    .lk        (lk.link)
  );

  // Two-stage synchronisers for everything from outside this domain
  localparam int SYNC_W = 14;

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;

  wire [SYNC_W-1:0] raw_w = {
    strap_level_i,
    enable_i,
    cc_attached_i,
    audio_acc_i,
    rp_code_i,
    dfp_role_i,
    ufp_valid_i,
    scl_pin_i,
    sda_pin_i,
    lk.sda_oe,
    lk.ctrl_reg[tcc_pkg::CTRL_CONDET_DIS],
    lk.clr_tgl
  };

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_w;
      sync2_r <= sync1_r;
    end
  end

  wire [1:0] strap_s  = sync2_r[13:12];
  wire       en_s     = sync2_r[11];
  wire       att_s    = sync2_r[10];
  wire       audio_s  = sync2_r[9];
  wire [1:0] rp_s     = sync2_r[8:7];
  wire       dfp_s    = sync2_r[6];
  wire       ufp_s    = sync2_r[5];
  wire       scl_s    = sync2_r[4];
  wire       sda_s    = sync2_r[3];
  wire       lk_oe_s  = sync2_r[2];
  wire       dis_s    = sync2_r[1];
  wire       clr_s    = sync2_r[0];

  // Strap latch after power-up
  logic [11:0]         latch_cnt_r;
  tcc_pkg::tcc_mode_t  mode_r;

  wire latch_due = (latch_cnt_r == tcc_pkg::STRAP_LATCH_CYC);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_cnt_r <= 12'h000;
    end else if (!latch_due) begin
      latch_cnt_r <= latch_cnt_r + 12'h001;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_r <= tcc_pkg::MODE_WAIT;
    end else if (latch_due && mode_r == tcc_pkg::MODE_WAIT) begin
      case (strap_s)
        tcc_pkg::STRAP_HI: mode_r <= tcc_pkg::MODE_I2C_HI;
        tcc_pkg::STRAP_LO: mode_r <= tcc_pkg::MODE_I2C_LO;
        default:           mode_r <= tcc_pkg::MODE_PLAIN;
      endcase
    end
  end

  wire is_i2c   = (mode_r == tcc_pkg::MODE_I2C_HI) ||
                  (mode_r == tcc_pkg::MODE_I2C_LO);
  wire is_plain = (mode_r == tcc_pkg::MODE_PLAIN);
  // Enable low parks every pin function
  wire active   = (mode_r != tcc_pkg::MODE_WAIT) & en_s;

  // Change detection on attach state and Rp current
  logic       att_prev_r;
  logic [1:0] rp_prev_r;
  logic       clr_prev_r;
  logic [1:0] evt_r;

  wire att_chg = active & (att_s != att_prev_r);
  wire rp_chg  = active & (rp_s != rp_prev_r);
  wire clr_evt = clr_s ^ clr_prev_r;

  // A new event in the clearing cycle survives
  wire [1:0] evt_set = {rp_chg, att_chg};
  wire [1:0] evt_nxt = active ?
    ((evt_r & ~{2{clr_evt}}) | evt_set) : 2'h0;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      att_prev_r <= 1'b0;
      rp_prev_r  <= tcc_pkg::RP_NONE;
      clr_prev_r <= 1'b0;
      evt_r      <= 2'h0;
    end else begin
      att_prev_r <= att_s;
      rp_prev_r  <= rp_s;
      clr_prev_r <= clr_s;
      evt_r      <= evt_nxt;
    end
  end

  // Frame tracking: link runs from START until STOP
  logic sda_prev_r;
  logic started_r;
  logic run_r;
  logic [7:0] snap_r;

  wire bus_ok  = active & is_i2c;
  wire start_w = bus_ok & scl_s & sda_prev_r & ~sda_s;
  wire stop_w  = bus_ok & scl_s & ~sda_prev_r & sda_s;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sda_prev_r <= 1'b1;
      started_r  <= 1'b0;
      run_r      <= 1'b0;
      snap_r     <= 8'h00;
    end else begin
      sda_prev_r <= sda_s;
      if (!bus_ok || start_w || stop_w) begin
        run_r <= 1'b0;
      end else if (started_r && !scl_s) begin
        run_r <= 1'b1;
      end
      if (start_w) begin
        started_r <= 1'b1;
        snap_r    <= {6'h00, evt_r};
      end else if (!bus_ok || stop_w || run_r) begin
        started_r <= 1'b0;
      end
    end
  end

  assign lk.run         = run_r;
  assign lk.sda_in      = sda_pin_i;
  assign lk.status_snap = snap_r;
  assign lk.i2c_addr    = (mode_r == tcc_pkg::MODE_I2C_HI) ?
                          tcc_pkg::I2C_ADDR_HI : tcc_pkg::I2C_ADDR_LO;

  // Current code to pin pattern; a zero pulls low
  wire [1:0] code_w =
    (rp_s == tcc_pkg::RP_MED)  ? 2'b10 :
    (rp_s == tcc_pkg::RP_HIGH) ? 2'b00 : 2'b11;

  // Pin function decode
  wire condet_en = active &
    (is_plain | (is_i2c & ~dis_s));
  wire pin6_nxt  = active &
    ((is_i2c & (|evt_r)) |
     (is_plain & audio_s));
  wire sda_nxt   = active &
    ((is_i2c & lk_oe_s) |
     (is_plain & ~code_w[0]));
  wire scl_nxt   = active & is_plain & ~code_w[1];
  wire role_nxt  = active & dfp_s & ufp_s;

  logic condet_oe_r;
  logic condet_r;
  logic pin6_oe_r;
  logic sda_oe_r;
  logic scl_oe_r;
  logic role_oe_r;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      condet_oe_r <= 1'b0;
      condet_r    <= 1'b0;
      pin6_oe_r   <= 1'b0;
      sda_oe_r    <= 1'b0;
      scl_oe_r    <= 1'b0;
      role_oe_r   <= 1'b0;
    end else begin
      condet_oe_r <= condet_en;
      condet_r    <= condet_en & att_s;
      pin6_oe_r   <= pin6_nxt;
      sda_oe_r    <= sda_nxt;
      scl_oe_r    <= scl_nxt;
      role_oe_r   <= role_nxt;
    end
  end

  // Pads other than connect detect are open drain and only ever drive low
  assign connect_detect_out_o     = condet_r;
  assign connect_detect_out_oe_o  = condet_oe_r;
  assign irq_audio_pin_o          = 1'b0;
  assign irq_audio_pin_oe_o       = pin6_oe_r;
  assign sda_pin_o                = 1'b0;
  assign sda_pin_oe_o             = sda_oe_r;
  assign scl_pin_o                = 1'b0;
  assign scl_pin_oe_o             = scl_oe_r;
  assign host_role_indicator_o    = 1'b0;
  assign host_role_indicator_oe_o = role_oe_r;

endmodule

// ---- tb/tcc_pin_mux_chk.sv ----
// Port-level checks on the pin-function block.
// Assumes straps held from reset release until the latch count runs out.
`timescale 1ns/1ps

module tcc_pin_mux_chk (
  // Clocks and reset
  input wire logic       clock_i,
  input wire logic       arst_n_i,
  input wire logic       scl_clk_i,
  // Straps and enable
  input wire logic [1:0] strap_level_i,
  input wire logic       enable_i,
  // Detector status
  input wire logic       cc_attached_i,
  input wire logic       audio_acc_i,
  input wire logic [1:0] rp_code_i,
  input wire logic       dfp_role_i,
  input wire logic       ufp_valid_i,
  // Pads
  input wire logic       connect_detect_out_o,
  input wire logic       connect_detect_out_oe_o,
  input wire logic       irq_audio_pin_o,
  input wire logic       irq_audio_pin_oe_o,
  input wire logic       sda_pin_i,
  input wire logic       sda_pin_o,
  input wire logic       sda_pin_oe_o,
  input wire logic       scl_pin_i,
  input wire logic       scl_pin_o,
  input wire logic       scl_pin_oe_o,
  input wire logic       host_role_indicator_o,
  input wire logic       host_role_indicator_oe_o
);
  logic [11:0] cnt_r;
  logic        i2c_r;
  wire         ready = cnt_r == 12'h7DA;
  wire         role_on = dfp_role_i && ufp_valid_i;
  wire         any_oe = connect_detect_out_oe_o | irq_audio_pin_oe_o
                      | sda_pin_oe_o | scl_pin_oe_o | host_role_indicator_oe_o;

  // Own copy of the strap latch, settled well after the design's
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 12'h000;
      i2c_r <= 1'b0;
    end else if (!ready) begin
      cnt_r <= cnt_r + 12'h001;
      i2c_r <= strap_level_i == 2'h0 || strap_level_i == 2'h2;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  pre_latch_quiet_a: assert property (
    cnt_r < 12'h7C6 |-> !any_oe) else $error("pad driven before latch");
  hib_release_a: assert property (
    !enable_i [*5] |-> !any_oe) else $error("pad driven in hibernation");
  condet_high_a: assert property (
    cc_attached_i [*4] ##0 connect_detect_out_oe_o |-> connect_detect_out_o)
    else $error("connect detect not high");
  condet_low_a: assert property (
    !cc_attached_i [*4] ##0 connect_detect_out_oe_o |-> !connect_detect_out_o)
    else $error("connect detect not low");
  role_on_a: assert property (
    (role_on && enable_i && ready) [*4] |-> host_role_indicator_oe_o)
    else $error("host role not pulled low");
  role_off_a: assert property (
    !role_on [*4] |-> !host_role_indicator_oe_o)
    else $error("host role pulled low");
  high_code_a: assert property (
    (!i2c_r && ready && enable_i && rp_code_i == 2'h3) [*4]
    |-> sda_pin_oe_o && scl_pin_oe_o) else $error("high code not 00");
  audio_flag_a: assert property (
    (!i2c_r && ready && enable_i && audio_acc_i) [*4] |-> irq_audio_pin_oe_o)
    else $error("audio flag not pulled low");
  irq_event_a: assert property (
    ($changed(cc_attached_i) && i2c_r && ready) ##0 enable_i [*5]
    |-> irq_audio_pin_oe_o) else $error("interrupt missing");
  i2c_no_code_a: assert property (
    i2c_r && ready |-> !scl_pin_oe_o) else $error("clock pad driven");

  cover property (i2c_r && $rose(irq_audio_pin_oe_o));
  cover property (i2c_r && $fell(irq_audio_pin_oe_o));
  cover property ($rose(connect_detect_out_oe_o));
  cover property (!i2c_r && sda_pin_oe_o && scl_pin_oe_o);
endmodule

bind tcc_pin_mux tcc_pin_mux_chk u_tcc_pin_mux_chk (.*);

// ---- tb/tcc_i2c_host.sv ----
// I2C controller model on the far side of the shared data and clock pads.
// Assumes pull-ups on both lines; pulls them low only, 125 ns per bit.
`timescale 1ns/1ps

module tcc_i2c_host (
  // Resolved data line
  input  wire logic sda_i,
  // Open-drain pull-downs
  output logic      sda_low_o,
  output logic      scl_low_o
);
  localparam realtime Q = 31.25;

  initial begin
    sda_low_o = 1'b0;
    scl_low_o = 1'b0;
  end

  task automatic bit_io(input logic b, output logic r);
    #Q sda_low_o = !b;
    #Q scl_low_o = 1'b0;
    #Q r = sda_i;
    #Q scl_low_o = 1'b1;
  endtask

  // Also serves as repeated start
  task automatic start();
    #Q sda_low_o = 1'b0;
    #Q scl_low_o = 1'b0;
    #Q sda_low_o = 1'b1;
    #Q scl_low_o = 1'b1;
  endtask

  task automatic stop();
    #Q sda_low_o = 1'b1;
    #Q scl_low_o = 1'b0;
    #Q sda_low_o = 1'b0;
    #Q;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ai,
                         output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, ak);
  endtask

  task automatic wr(input logic [7:0] a, r, v, output logic nak);
    logic [7:0] q;
    logic [2:0] k;
    start();
    byte_io(a, 1'b1, q, k[0]);
    byte_io(r, 1'b1, q, k[1]);
    byte_io(v, 1'b1, q, k[2]);
    stop();
    nak = |k;
  endtask

  // Single byte, ended by a NACK
  task automatic rd(input logic [7:0] a, r, output logic [7:0] v);
    logic [7:0] q;
    logic       k;
    start();
    byte_io(a, 1'b1, q, k);
    byte_io(r, 1'b1, q, k);
    start();
    byte_io(a | 8'h01, 1'b1, q, k);
    byte_io(8'hFF, 1'b1, v, k);
    stop();
  endtask
endmodule

// ---- tb/tcc_pin_mux_tb_top.sv ----
// Self-checking bench for the pin-function block, plain and I2C modes.
// Assumes pads with pull-ups; the SCL line also clocks the link.
`timescale 1ns/1ps

module tcc_pin_mux_tb_top;
  logic       clock_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [1:0] strap_level_i = 2'h1;
  logic       enable_i = 1'b1;
  logic       cc_attached_i = 1'b0;
  logic       audio_acc_i = 1'b0;
  logic [1:0] rp_code_i = 2'h0;
  logic       dfp_role_i = 1'b0;
  logic       ufp_valid_i = 1'b0;
  logic       sda_low, scl_low, connect_detect_out_o, connect_detect_out_oe_o,
              irq_audio_pin_o, irq_audio_pin_oe_o, sda_pin_o, sda_pin_oe_o,
              scl_pin_o, scl_pin_oe_o, host_role_indicator_o,
              host_role_indicator_oe_o;
  wire        sda_pin_i = !(sda_pin_oe_o || sda_low);
  wire        scl_pin_i = !(scl_pin_oe_o || scl_low);
  wire        scl_clk_i = scl_pin_i;
  wire  [7:0] pins = {2'h0, connect_detect_out_oe_o, connect_detect_out_o,
                irq_audio_pin_oe_o, scl_pin_i, sda_pin_i,
                host_role_indicator_oe_o};
  logic [7:0] code_exp [4] = '{8'h06, 8'h06, 8'h04, 8'h00};
  logic       ev_cc [3] = '{1'b1, 1'b1, 1'b0};
  logic [1:0] ev_rp [3] = '{2'h0, 2'h2, 2'h3};
  logic [7:0] ev_st [3] = '{8'h01, 8'h02, 8'h03};
  int         n_errors = 0;
  int         samples_checked = 0;
  int         tick = 0;
  logic [7:0] d;
  logic       nak;

  tcc_pin_mux u_tcc_pin_mux (.*);

  tcc_i2c_host u_tcc_i2c_host (
    .sda_i     (sda_pin_i),
    .sda_low_o (sda_low),
    .scl_low_o (scl_low)
  );

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic boot(input logic [1:0] s);
    strap_level_i = s;
    enable_i = 1'b1;
    cc_attached_i = 1'b0;
    rp_code_i = 2'h0;
    arst_n_i = 1'b0;
    cyc(8);
    arst_n_i = 1'b1;
    cyc(2010);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clock_i) begin
    tick++;
    if (tick == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    boot(2'h1);
    chk("plain idle", pins, 8'h26);
    cc_attached_i = 1'b1;
    audio_acc_i = 1'b1;
    dfp_role_i = 1'b1;
    ufp_valid_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rp_code_i = 2'(i);
      cyc(5);
      chk("plain pins", pins, 8'h39 | code_exp[i]);
    end
    chk("od levels", {4'h0, irq_audio_pin_o, sda_pin_o, scl_pin_o,
        host_role_indicator_o}, 8'h00);
    enable_i = 1'b0;
    cyc(6);
    chk("plain hib", pins, 8'h06);
    $display("plain mode test done");
    boot(2'h2);
    chk("i2c idle", pins, 8'h07);
    u_tcc_i2c_host.rd(8'h7C, 8'h09, d);
    chk("ctrl reset", d, 8'h01);
    u_tcc_i2c_host.wr(8'h3C, 8'h09, 8'h00, nak);
    chk("foreign addr", {7'h0, nak}, 8'h01);
    u_tcc_i2c_host.wr(8'h7C, 8'h09, 8'h00, nak);
    chk("own addr", {7'h0, nak}, 8'h00);
    cyc(5);
    chk("condet on", pins, 8'h27);
    for (int i = 0; i < 3; i++) begin
      cc_attached_i = ev_cc[i];
      rp_code_i = ev_rp[i];
      cyc(6);
      chk("irq set", pins, 8'h2F | {3'h0, ev_cc[i], 4'h0});
      u_tcc_i2c_host.rd(8'h7C, 8'h19, d);
      chk("evt status", d, ev_st[i]);
      cyc(5);
      chk("irq clear", pins, 8'h27 | {3'h0, ev_cc[i], 4'h0});
    end
    u_tcc_i2c_host.wr(8'h7C, 8'h02, 8'h5A, nak);
    cyc(1);
    enable_i = 1'b0;
    cyc(6);
    chk("i2c hib", pins, 8'h06);
    enable_i = 1'b1;
    cyc(8);
    u_tcc_i2c_host.rd(8'h7C, 8'h02, d);
    chk("cfg kept", d, 8'h5A);
    u_tcc_i2c_host.rd(8'h7C, 8'h09, d);
    chk("ctrl kept", d, 8'h00);
    cyc(1);
    chk("condet back", pins, 8'h27);
    $display("i2c mode test done");
    wrap_up();
  end
endmodule
